// ### tb/dv_output_and_gyro_bias_regs_tb.sv
// self-checking bench for the z delta-velocity and gyro offset bank
`timescale 1ns/1ps
module dv_output_and_gyro_bias_regs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic [31:0] gx = 32'h0000_0000;
    logic [31:0] gy = 32'h0000_0000;
    logic [31:0] gz = 32'h0000_0000;
    logic [31:0] az = 32'h0000_1000;
    logic [10:0] dec = 11'h001;
    logic bkp = 1'b0;
    logic [31:0] cx;
    logic [31:0] cy;
    logic [31:0] cz;
    logic cv;
    logic dvr;
    logic tick;
    int n_cyc;
    localparam int sample_cyc = 8;
    int fails = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    dvg_host i_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid));

    // short sample period keeps the full decimation run affordable
    // shift of 11 lets a full-scale period reach the 32-bit saturation
    dvg_regs #(.SAMPLE_CYC(sample_cyc), .DV_SHIFT(11)) i_dut (.CLK(clk), .RST(rst),
        .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .GYRO_X(gx), .GYRO_Y(gy),
        .GYRO_Z(gz), .ACC_Z(az), .DEC_SETTING(dec), .BKP_LOAD(bkp),
        .BKP_X(32'h0002_0005), .BKP_Y(32'hffff_fffe), .BKP_Z(32'h0003_0000),
        .SAMPLE_TICK(tick), .GX_CORR(cx), .GY_CORR(cy), .GZ_CORR(cz),
        .CORR_VALID(cv), .DV_READY(dvr));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        i_host.rd_reg(a, d, v);
        chk({31'h0, v}, 32'h1);
        chk({16'h0, d}, {16'h0, exp});
    endtask : rchk

    // sel 0 waits for corrected samples, sel 1 for a delta-velocity update
    task automatic wait_ev(input logic sel);
        int n;
        n = 0;
        @(posedge clk);
        while ((sel ? dvr : cv) !== 1'b1 && n < 40000)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n < 40000}, 32'h1);
    endtask : wait_ev

    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // four long decimation periods dominate the run
    initial
    begin
        #2_000_000;
        fails++;
        test_done();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rchk(7'h40 + 7'(2 * i), 16'h0000);
        rchk(7'h50, 16'h0000);
        $display("test reset values done");
        // tick every sample period, corrected strobe one cycle behind it
        while (tick !== 1'b1)
            @(posedge clk);
        @(posedge clk);
        chk({31'h0, cv}, 32'h1);
        n_cyc = 1;
        while (tick !== 1'b1 && n_cyc < 100)
        begin
            @(posedge clk);
            n_cyc++;
        end
        chk(32'(n_cyc), 32'(sample_cyc));
        $display("test sample tick done");
        for (int i = 0; i < 6; i++)
            i_host.wr_reg(7'h40 + 7'(2 * i), 16'h1111 * 16'(i + 1));
        for (int i = 0; i < 6; i++)
            rchk(7'h40 + 7'(2 * i), 16'h1111 * 16'(i + 1));
        $display("test offset access done");
        i_host.wr_reg(7'h40, 16'h0010);
        i_host.wr_reg(7'h42, 16'h0000);
        i_host.wr_reg(7'h44, 16'hfff0);
        i_host.wr_reg(7'h46, 16'hffff);
        i_host.wr_reg(7'h48, 16'h0000);
        i_host.wr_reg(7'h4a, 16'h0001);
        gx <= 32'h0000_0100;
        gy <= 32'h0000_0100;
        gz <= 32'h7fff_ffff;
        // the first update may still carry the old samples
        wait_ev(1'b0);
        wait_ev(1'b0);
        chk(cx, 32'h0000_0110);
        chk(cy, 32'h0000_00f0);
        chk(cz, 32'h7fff_ffff);
        $display("test offset correction done");
        @(posedge clk);
        bkp <= 1'b1;
        @(posedge clk);
        bkp <= 1'b0;
        rchk(7'h40, 16'h0005);
        rchk(7'h42, 16'h0002);
        rchk(7'h46, 16'hffff);
        rchk(7'h4a, 16'h0003);
        $display("test backup restore done");
        wait_ev(1'b1);
        rchk(7'h3a, 16'h0000);
        rchk(7'h38, 16'h0008);
        i_host.wr_reg(7'h3a, 16'h5555);
        i_host.wr_reg(7'h38, 16'haaaa);
        rchk(7'h3a, 16'h0000);
        rchk(7'h38, 16'h0008);
        for (int i = 0; i < 2; i++)
        begin
            az <= i ? 32'h7fff_ffff : 32'h8000_0000;
            dec <= 11'h7ff;
            wait_ev(1'b1);
            wait_ev(1'b1);
            rchk(7'h3a, i ? 16'h7fff : 16'h8000);
            rchk(7'h38, i ? 16'hffff : 16'h0000);
        end
        $display("test delta velocity done");
        test_done();
    end
endmodule : dv_output_and_gyro_bias_regs_tb

// ### tb/dvg_host.sv
// host model driving the parallel register strobe port
`timescale 1ns/1ps
module dvg_host
(
    input wire logic clk,
    output logic [6:0] addr,
    output logic wr,
    output logic rd,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    initial
    begin
        addr = 7'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
    end
    // released lines show the inverse so a stale value is never trusted
    task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : wr_reg
    // answer comes exactly one edge after the taken edge
    task automatic rd_reg(input logic [6:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        v = rvalid;
        d = rdata;
    endtask : rd_reg
endmodule : dvg_host

// ### verilog/dvg_bias_add.sv
// one axis of gyro offset correction with saturating add
`timescale 1ns/1ps
`include "dvg_defs.svh"
module dvg_bias_add
(
    input wire logic clk,
    input wire logic rst,
    input wire logic stb,
    input wire logic [31:0] sample,
    input wire logic [31:0] bias,
    output logic [31:0] corr,
    output logic valid
);
    logic [31:0] corr_q;
    logic [31:0] corr_d;
    logic valid_q;
    logic [32:0] sum;

    always_comb
    begin
        sum = {sample[31], sample} + {bias[31], bias};
        corr_d = corr_q;
        if (stb)
        begin
            // clamp rather than wrap so a large offset cannot flip the sign
            if (sum[32] != sum[31])
                corr_d = sum[32] ? `DVG_DV_MIN : `DVG_DV_MAX;
            else
                corr_d = sum[31:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            corr_q <= 32'h0000_0000;
            valid_q <= 1'b0;
        end
        else
        begin
            corr_q <= corr_d;
            valid_q <= stb;
        end
    end

    assign corr = corr_q;
    assign valid = valid_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_bias_sum: assert property (stb && (sum[32] == sum[31]) |=>
        corr == $past(sample) + $past(bias) && valid)
        else $error("corrected sample is not sample plus offset");
    a_bias_clamp: assert property (stb && (sum[32] != sum[31]) |=>
        (corr == `DVG_DV_MAX) || (corr == `DVG_DV_MIN))
        else $error("overflowing correction did not saturate");
endmodule : dvg_bias_add

// ### verilog/dvg_defs.svh
// constants for the delta-velocity output and gyro offset register bank
// Behaviour
// - z delta-velocity low word is read-only, holds extra resolution bits
// - z delta-velocity high word is read-only twos complement, zero reads 0x0000
// - 16-bit form saturates at 0x7fff and uses 0x8000 for full negative
// - high and low words form 32-bit twos complement, full negative 0x80000000
// - user offsets follow factory correction in the 2000 Hz sample chain
// - factory coefficients stay hidden; each gyro axis has its own offset
// - x offset is low and high read/write words, high is upper half
// - y offset is low and high words forming one 32-bit value
// - z offset is low and high words forming one 32-bit value
// - offset words use the same encoding as the gyro outputs
// - y and z offsets act on their axes exactly as x does
// - delta velocity is trapezoidal sum over decimation period, halved rate scale
`ifndef DVG_DEFS_SVH
`define DVG_DEFS_SVH

`define DVG_ADDR_W 7
`define DVG_OFS_DV_LOW 7'h38
`define DVG_OFS_DV_HIGH 7'h3a
`define DVG_OFS_XB_LOW 7'h40
`define DVG_OFS_XB_HIGH 7'h42
`define DVG_OFS_YB_LOW 7'h44
`define DVG_OFS_YB_HIGH 7'h46
`define DVG_OFS_ZB_LOW 7'h48
`define DVG_OFS_ZB_HIGH 7'h4a
`define DVG_BIAS_RESET 32'h0000_0000
`define DVG_DV_MAX 32'h7fff_ffff
`define DVG_DV_MIN 32'h8000_0000
`define DVG_CLK_HZ 40000000
`define DVG_FS_HZ 2000
`define DVG_SAMPLE_CYC (`DVG_CLK_HZ / `DVG_FS_HZ)
`define DVG_DV_SHIFT 12
`define DVG_DEC_W 11

`endif

// ### verilog/dvg_pkg.sv
// types shared by the delta-velocity and gyro offset bank
package dvg_pkg;
    typedef logic signed [31:0] dvg_word_t;
    typedef logic signed [47:0] dvg_acc_t;
    typedef enum logic [1:0]
    {
        DVG_PRIME = 2'b00,
        DVG_RUN = 2'b01
    } dvg_state_t;
endpackage : dvg_pkg

// ### verilog/dvg_regs.sv
// delta-velocity z output words and x/y/z gyro offset registers
`timescale 1ns/1ps
`include "dvg_defs.svh"
module dvg_regs
#(
    parameter int SAMPLE_CYC = `DVG_SAMPLE_CYC,
    parameter int DV_SHIFT = `DVG_DV_SHIFT
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [6:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic [31:0] GYRO_X,
    input wire logic [31:0] GYRO_Y,
    input wire logic [31:0] GYRO_Z,
    input wire logic [31:0] ACC_Z,
    input wire logic [10:0] DEC_SETTING,
    input wire logic BKP_LOAD,
    input wire logic [31:0] BKP_X,
    input wire logic [31:0] BKP_Y,
    input wire logic [31:0] BKP_Z,
    output logic SAMPLE_TICK,
    output logic [31:0] GX_CORR,
    output logic [31:0] GY_CORR,
    output logic [31:0] GZ_CORR,
    output logic CORR_VALID,
    output logic DV_READY
);
    // sample-rate divider, stands in for the internal sample clock
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic tick_q;
    logic tick_d;

    always_comb
    begin
        tick_d = (div_q == 16'h0000);
        if (div_q == 16'h0000)
            div_d = 16'(SAMPLE_CYC - 1);
        else
            div_d = div_q - 16'h0001;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    assign SAMPLE_TICK = tick_q;

    // register write side: offset words and backup restore
    logic [6:0] waddr;
    logic [31:0] xb_q;
    logic [31:0] xb_d;
    logic [31:0] yb_q;
    logic [31:0] yb_d;
    logic [31:0] zb_q;
    logic [31:0] zb_d;

    assign waddr = {REG_ADDR[6:1], 1'b0};

    always_comb
    begin
        xb_d = xb_q;
        yb_d = yb_q;
        zb_d = zb_q;
        // restore happens whenever BKP_LOAD is high; it overrides a host write in the same cycle
        if (BKP_LOAD)
        begin
            xb_d = BKP_X;
            yb_d = BKP_Y;
            zb_d = BKP_Z;
        end
        else if (REG_WR)
        begin
            case (waddr)
                `DVG_OFS_XB_LOW: xb_d[15:0] = REG_WDATA;
                `DVG_OFS_XB_HIGH: xb_d[31:16] = REG_WDATA;
                `DVG_OFS_YB_LOW: yb_d[15:0] = REG_WDATA;
                `DVG_OFS_YB_HIGH: yb_d[31:16] = REG_WDATA;
                `DVG_OFS_ZB_LOW: zb_d[15:0] = REG_WDATA;
                `DVG_OFS_ZB_HIGH: zb_d[31:16] = REG_WDATA;
                // delta-velocity words are read-only, writes fall through
                default: xb_d = xb_q;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            xb_q <= `DVG_BIAS_RESET;
            yb_q <= `DVG_BIAS_RESET;
            zb_q <= `DVG_BIAS_RESET;
        end
        else
        begin
            xb_q <= xb_d;
            yb_q <= yb_d;
            zb_q <= zb_d;
        end
    end

    // per-axis offset, applied to the factory-corrected sample on each tick
    dvg_bias_add u_bias_x
    (
        .clk(CLK),
        .rst(RST),
        .stb(tick_q),
        .sample(GYRO_X),
        .bias(xb_q),
        .corr(GX_CORR),
        .valid(CORR_VALID)
    );
    dvg_bias_add u_bias_y
    (
        .clk(CLK),
        .rst(RST),
        .stb(tick_q),
        .sample(GYRO_Y),
        .bias(yb_q),
        .corr(GY_CORR),
        .valid()
    );
    dvg_bias_add u_bias_z
    (
        .clk(CLK),
        .rst(RST),
        .stb(tick_q),
        .sample(GYRO_Z),
        .bias(zb_q),
        .corr(GZ_CORR),
        .valid()
    );

    // trapezoidal integration of z acceleration
    dvg_pkg::dvg_state_t st_q;
    dvg_pkg::dvg_state_t st_d;
    dvg_pkg::dvg_acc_t acc_q;
    dvg_pkg::dvg_acc_t acc_d;
    dvg_pkg::dvg_acc_t acc_sum;
    dvg_pkg::dvg_acc_t acc_scaled;
    logic [31:0] prev_q;
    logic [31:0] prev_d;
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic [31:0] dv_q;
    logic [31:0] dv_d;
    logic rdy_q;
    logic rdy_d;
    logic dump;

    always_comb
    begin
        st_d = st_q;
        acc_d = acc_q;
        prev_d = prev_q;
        cnt_d = cnt_q;
        dv_d = dv_q;
        rdy_d = 1'b0;
        dump = 1'b0;
        acc_sum = acc_q + 48'(signed'(ACC_Z)) + 48'(signed'(prev_q));
        // shift stands for the 1/(2*fs) scale; width headroom covers 2048 taps
        acc_scaled = acc_sum >>> DV_SHIFT;
        case (st_q)
            dvg_pkg::DVG_PRIME:
            begin
                // the first sample only seeds the previous-sample term
                if (tick_q)
                begin
                    prev_d = ACC_Z;
                    st_d = dvg_pkg::DVG_RUN;
                end
            end
            dvg_pkg::DVG_RUN:
            begin
                if (tick_q)
                begin
                    prev_d = ACC_Z;
                    if (cnt_q == DEC_SETTING)
                    begin
                        dump = 1'b1;
                        cnt_d = 11'h000;
                        acc_d = 48'sh0;
                        rdy_d = 1'b1;
                        if (acc_scaled > 48'sh0000_7fff_ffff)
                            dv_d = `DVG_DV_MAX;
                        else if (acc_scaled < -48'sh0000_8000_0000)
                            dv_d = `DVG_DV_MIN;
                        else
                            dv_d = acc_scaled[31:0];
                    end
                    else
                    begin
                        cnt_d = cnt_q + 11'h001;
                        acc_d = acc_sum;
                    end
                end
            end
            default:
            begin
                st_d = dvg_pkg::DVG_PRIME;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            st_q <= dvg_pkg::DVG_PRIME;
            acc_q <= 48'sh0;
            prev_q <= 32'h0000_0000;
            cnt_q <= 11'h000;
            dv_q <= 32'h0000_0000;
            rdy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            acc_q <= acc_d;
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            dv_q <= dv_d;
            rdy_q <= rdy_d;
        end
    end

    assign DV_READY = rdy_q;

    // register read side, answer one cycle after the strobe
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;

    always_comb
    begin
        rdata_d = rdata_q;
        if (REG_RD)
        begin
            case (waddr)
                `DVG_OFS_DV_LOW: rdata_d = dv_q[15:0];
                `DVG_OFS_DV_HIGH: rdata_d = dv_q[31:16];
                `DVG_OFS_XB_LOW: rdata_d = xb_q[15:0];
                `DVG_OFS_XB_HIGH: rdata_d = xb_q[31:16];
                `DVG_OFS_YB_LOW: rdata_d = yb_q[15:0];
                `DVG_OFS_YB_HIGH: rdata_d = yb_q[31:16];
                `DVG_OFS_ZB_LOW: rdata_d = zb_q[15:0];
                `DVG_OFS_ZB_HIGH: rdata_d = zb_q[31:16];
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= REG_RD;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_low_word_read: assert property (REG_RD && waddr == `DVG_OFS_DV_LOW |=>
        REG_RVALID && REG_RDATA == $past(dv_q[15:0]))
        else $error("low delta-velocity word read mismatch");
    a_high_word_read: assert property (REG_RD && waddr == `DVG_OFS_DV_HIGH |=>
        REG_RVALID && REG_RDATA == $past(dv_q[31:16]))
        else $error("high delta-velocity word read mismatch");
    a_dv_sat_pos: assert property (dump && acc_scaled > 48'sh0000_7fff_ffff |=>
        dv_q[31:16] == 16'h7fff && dv_q[15:0] == 16'hffff)
        else $error("positive delta velocity did not saturate");
    a_dv_sat_neg: assert property (dump && acc_scaled < -48'sh0000_8000_0000 |=>
        dv_q == `DVG_DV_MIN)
        else $error("negative delta velocity not full-scale negative");
    a_tick_spacing: assert property (tick_q |=> !tick_q [*2])
        else $error("sample ticks too close together");
    a_corr_follows: assert property (tick_q |=> CORR_VALID ##1 !CORR_VALID)
        else $error("corrected sample valid not one cycle after tick");
    a_x_high_write: assert property (REG_WR && !BKP_LOAD && waddr == `DVG_OFS_XB_HIGH |=>
        xb_q[31:16] == $past(REG_WDATA) && xb_q[15:0] == $past(xb_q[15:0]))
        else $error("x offset upper word not written");
    a_z_low_write: assert property (REG_WR && !BKP_LOAD && waddr == `DVG_OFS_ZB_LOW |=>
        zb_q[15:0] == $past(REG_WDATA))
        else $error("z offset lower word not written");
    a_bkp_restore: assert property (BKP_LOAD |=>
        xb_q == $past(BKP_X) && yb_q == $past(BKP_Y) && zb_q == $past(BKP_Z))
        else $error("backup restore did not load offsets");
    a_dv_dump: assert property (dump |=> DV_READY && cnt_q == 11'h000 && acc_q == 48'sh0)
        else $error("decimation period end not handled");

    c_dv_update: cover property (DV_READY);
    c_dv_saturate: cover property (dump && acc_scaled > 48'sh0000_7fff_ffff);
    c_bias_write: cover property (REG_WR && waddr == `DVG_OFS_YB_HIGH);
    c_restore: cover property (BKP_LOAD);
endmodule : dvg_regs
